//--- pkg/measure_pkg.sv
// constants, encodings and register map of the signal measurement timer core
// assumes one 10 MHz clock and the byte-wide register port of the top module
//
// Summary of operation
// (RULE1) 24-bit up-counter, optional 16-bit width
// (RULE2) counter readable/writable as three bytes
// (RULE3) 3-bit field picks counter clock source
// (RULE4) 2-bit prescale drives counter and synchronisers
// (RULE5) count equals limit: roll to zero, interrupt
// (RULE6) software sets limit above expected period
// (RULE7) clear bit zeroes all counter bits
// (RULE8) software touches counter only while stopped
// (RULE9) width latch captures on mode trigger
// (RULE10) width load bit copies counter to latch
// (RULE11) period latch captures on other trigger
// (RULE12) period load bit copies counter to latch
// (RULE13) acquisition complete raises its own interrupt
// (RULE14) input levels readable in status bits
// (RULE15) counter, limit, latches all software writable
// (RULE16) two independent identical timer instances
// (RULE17) timer mode counts while run bit set
// (RULE18) single acquisition stops and clears run bit
// (RULE19) 16-bit mode compares low half, upper zero
package measure_pkg;
  localparam int UNITS = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W = 24;
  localparam int SYNC_STAGES = 2;
  localparam int SYSTEM_DIVIDE = 4;
  localparam int MID_DIVIDE = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register indices within one instance; addr[5] picks the instance
  localparam logic [4:0] REG_COUNT = 5'h00;
  localparam logic [4:0] REG_LIMIT = 5'h03;
  localparam logic [4:0] REG_WIDTH = 5'h06;
  localparam logic [4:0] REG_PERIOD = 5'h09;
  localparam logic [4:0] REG_CLOCK = 5'h0c;
  localparam logic [4:0] REG_CTL0 = 5'h0d;
  localparam logic [4:0] REG_CTL1 = 5'h0e;
  localparam logic [4:0] REG_STATUS = 5'h0f;
  localparam logic [4:0] REG_IRQ_STAT = 5'h10;
  localparam logic [4:0] REG_IRQ_MASK = 5'h11;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTL0_PS_LSB = 0;
  localparam int CTL0_NARROW_BIT = 2;
  localparam int CTL0_REPEAT_BIT = 3;
  localparam int CTL1_MODE_LSB = 0;
  localparam int CTL1_RUN_BIT = 7;
  localparam int STAT_WLOAD_BIT = 7;
  localparam int STAT_PLOAD_BIT = 6;
  localparam int STAT_CLEAR_BIT = 4;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_WIN_BIT = 1;
  localparam int STAT_SIG_BIT = 0;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_ACQ_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [23:0] LIMIT_RESET = 24'hff_ffff;
  localparam logic [23:0] COUNT_RESET = 24'h00_0000;
  localparam logic [23:0] COUNT_ONE = 24'h00_0001;

  typedef enum logic [2:0] {
    CS_SYSTEM = 3'h0,
    CS_SYSTEM_DIV4 = 3'h1,
    CS_FAST = 3'h2,
    CS_SLOW = 3'h3,
    CS_MID_DIV = 3'h4
  } clock_source_t;

  typedef enum logic [3:0] {
    MODE_TIMER = 4'h0,
    MODE_GATED = 4'h1,
    MODE_DUTY = 4'h2,
    MODE_HILO = 4'h3,
    MODE_WINDOW = 4'h4,
    MODE_GATED_WINDOW = 4'h5,
    MODE_FLIGHT = 4'h6,
    MODE_CAPTURE = 4'h7
  } measure_mode_t;
endpackage

//--- pkg/edge_if.sv
// synchronised level and edge flags of one measurement input
// assumes the producer updates them only on prescaled ticks
`timescale 1ns/1ns
`default_nettype none
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport source(output level, output rise, output fall);
  modport sink(input level, input rise, input fall);
endinterface
`default_nettype wire

//--- design/clock_prescaler.sv
// counter clock source select and prescaler, as a one-cycle tick
// assumes oscillator inputs are one-cycle enable pulses on mclk
`timescale 1ns/1ns
`default_nettype none
module clock_prescaler
  import measure_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] clock_source_select,
  input wire logic [1:0] prescale_select,
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic mid_tick,
  output logic tick
);
  logic [1:0] sys_div;
  logic [3:0] mid_div;
  logic [2:0] pre_cnt;
  logic [2:0] pre_limit;
  logic src;

  always_ff @(posedge mclk) begin
    if (!rst_n) sys_div <= 2'h0;
    else sys_div <= sys_div + 2'h1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) mid_div <= 4'h0;
    else if (mid_tick) mid_div <= mid_div + 4'h1;
  end

  always_comb begin
    unique case (clock_source_t'(clock_source_select)) // RULE3
      CS_SYSTEM: src = 1'b1;
      CS_SYSTEM_DIV4: src = (sys_div == 2'(SYSTEM_DIVIDE - 1));
      CS_FAST: src = fast_tick;
      CS_SLOW: src = slow_tick;
      CS_MID_DIV: src = mid_tick && (mid_div == 4'(MID_DIVIDE - 1));
      default: src = 1'b0;
    endcase
  end

  // divide by 1, 2, 4 or 8
  assign pre_limit = 3'((4'h1 << prescale_select) - 4'h1);

  always_ff @(posedge mclk) begin
    if (!rst_n) pre_cnt <= 3'h0;
    else if (src) pre_cnt <= (pre_cnt >= pre_limit) ? 3'h0 : pre_cnt + 3'h1; // RULE4
  end

  assign tick = src && (pre_cnt >= pre_limit);
endmodule
`default_nettype wire

//--- design/edge_sync.sv
// synchroniser and edge detector clocked by the prescaled tick
// assumes edge flags are only consumed together with tick
`timescale 1ns/1ns
`default_nettype none
module edge_sync
  import measure_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic raw,
  edge_if.source ev
);
  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else if (tick) begin // RULE4
      meta <= raw;
      stable <= meta;
      prev <= stable;
    end
  end

  assign ev.level = stable;
  assign ev.rise = stable && !prev;
  assign ev.fall = !stable && prev;
endmodule
`default_nettype wire

//--- design/signal_measure_timer_core.sv
// two signal measurement timers behind one byte-wide register port
// assumes synchronous inputs, oscillator ticks as enables, single clock mclk
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module signal_measure_timer_core
  import measure_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic fast_internal_oscillator_tick,
  input wire logic slow_internal_oscillator_tick,
  input wire logic mid_internal_oscillator_tick,
  input wire logic [UNITS-1:0] window_in,
  input wire logic [UNITS-1:0] signal_in,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic in_group(input logic [4:0] idx, input logic [4:0] base);
    in_group = (idx >= base) && (idx < base + 5'h3);
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [4:0] lane,
                                           input logic [7:0] b);
    logic [23:0] r;
    r = v;
    unique case (lane[1:0])
      2'h0: r[7:0] = b;
      2'h1: r[15:8] = b;
      default: r[23:16] = b;
    endcase
    put_byte = r;
  endfunction

  function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [4:0] lane);
    unique case (lane[1:0])
      2'h0: get_byte = v[7:0];
      2'h1: get_byte = v[15:8];
      default: get_byte = v[23:16];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-instance state

  logic [CNT_W-1:0] measure_count [UNITS];
  logic [CNT_W-1:0] period_limit [UNITS];
  logic [CNT_W-1:0] pulse_width_latch [UNITS];
  logic [CNT_W-1:0] period_latch [UNITS];
  logic [2:0] clock_source_select [UNITS];
  logic [1:0] prescale_select [UNITS];
  logic narrow [UNITS];
  logic repeat_on [UNITS];
  logic run_request [UNITS];
  measure_mode_t mode [UNITS];
  logic running [UNITS];
  logic armed [UNITS];
  logic [1:0] irq_status [UNITS];
  logic [1:0] irq_mask [UNITS];
  logic [DATA_W-1:0] rd_view [UNITS];
  logic [UNITS-1:0] irq_unit;
  logic [4:0] idx;

  assign idx = addr[4:0];

  generate
    for (genvar i = 0; i < UNITS; i++) begin : g_unit // RULE16
      localparam logic UNIT = 1'(i);
      logic tick;
      logic sel;
      logic wr_count;
      logic wr_limit;
      logic wr_width;
      logic wr_period;
      logic wr_status;
      logic clear_req;
      logic wload_req;
      logic pload_req;
      logic step;
      logic inc;
      logic hw_reset;
      logic to_one;
      logic w_evt;
      logic p_evt;
      logic acq;
      logic arm_set;
      logic arm_clr;
      logic match;
      logic [CNT_W-1:0] count_next;
      edge_if win_ev ();
      edge_if sig_ev ();

      clock_prescaler u_prescaler (
        .mclk(mclk),
        .rst_n(rst_n),
        .clock_source_select(clock_source_select[i]),
        .prescale_select(prescale_select[i]),
        .fast_tick(fast_internal_oscillator_tick),
        .slow_tick(slow_internal_oscillator_tick),
        .mid_tick(mid_internal_oscillator_tick),
        .tick(tick)
      );

      edge_sync u_win_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick),
        .raw(window_in[i]),
        .ev(win_ev)
      );

      edge_sync u_sig_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick),
        .raw(signal_in[i]),
        .ev(sig_ev)
      );

      //////////////////////////////////////////////////////////////////////
      // register port decode

      assign sel = (addr[5] == UNIT);
      assign wr_count = wr_en && sel && in_group(idx, REG_COUNT); // RULE2
      assign wr_limit = wr_en && sel && in_group(idx, REG_LIMIT); // RULE15
      assign wr_width = wr_en && sel && in_group(idx, REG_WIDTH);
      assign wr_period = wr_en && sel && in_group(idx, REG_PERIOD);
      assign wr_status = wr_en && sel && (idx == REG_STATUS);
      assign clear_req = wr_status && wdata[STAT_CLEAR_BIT];
      assign wload_req = wr_status && wdata[STAT_WLOAD_BIT];
      assign pload_req = wr_status && wdata[STAT_PLOAD_BIT];

      //////////////////////////////////////////////////////////////////////
      // mode dependent triggers, sampled on the prescaled tick

      assign step = tick && run_request[i];
      assign match = narrow[i] ? (measure_count[i][15:0] == period_limit[i][15:0]) // RULE19
                               : (measure_count[i] == period_limit[i]);

      always_comb begin
        inc = 1'b1;
        hw_reset = 1'b0;
        to_one = 1'b0;
        w_evt = 1'b0;
        p_evt = 1'b0;
        acq = 1'b0;
        arm_set = 1'b0;
        arm_clr = 1'b0;
        unique case (mode[i])
          MODE_TIMER: inc = 1'b1; // RULE17
          MODE_GATED: begin
            inc = sig_ev.level;
            w_evt = sig_ev.fall;
            acq = sig_ev.fall;
          end
          MODE_DUTY: begin
            w_evt = sig_ev.fall;
            p_evt = sig_ev.rise;
            hw_reset = sig_ev.rise;
            to_one = 1'b1;
            acq = sig_ev.rise;
          end
          MODE_HILO: begin
            inc = armed[i];
            arm_set = sig_ev.rise;
            w_evt = armed[i] && sig_ev.fall;
            p_evt = armed[i] && sig_ev.rise;
            hw_reset = sig_ev.rise || sig_ev.fall;
            acq = armed[i] && sig_ev.rise;
          end
          MODE_WINDOW: begin
            inc = armed[i];
            arm_set = win_ev.rise;
            p_evt = armed[i] && win_ev.rise;
            hw_reset = win_ev.rise;
            acq = armed[i] && win_ev.rise;
          end
          MODE_GATED_WINDOW: begin
            inc = armed[i] && sig_ev.level;
            arm_set = win_ev.rise;
            p_evt = armed[i] && win_ev.rise;
            hw_reset = win_ev.rise;
            acq = armed[i] && win_ev.rise;
          end
          MODE_FLIGHT: begin
            inc = armed[i];
            arm_set = win_ev.rise;
            arm_clr = armed[i] && sig_ev.rise && !win_ev.rise;
            p_evt = armed[i] && sig_ev.rise;
            w_evt = armed[i] && win_ev.rise && !sig_ev.rise;
            hw_reset = win_ev.rise || (armed[i] && sig_ev.rise);
            acq = armed[i] && (sig_ev.rise || win_ev.rise);
          end
          MODE_CAPTURE: begin
            p_evt = win_ev.rise;
            w_evt = win_ev.fall;
            acq = win_ev.rise || win_ev.fall;
          end
          default: inc = 1'b1;
        endcase
      end

      //////////////////////////////////////////////////////////////////////
      // time base

      always_comb begin
        count_next = measure_count[i];
        if (hw_reset) count_next = to_one ? COUNT_ONE : COUNT_RESET;
        else if (match) count_next = COUNT_RESET; // RULE5
        else if (inc) count_next = measure_count[i] + 24'h00_0001; // RULE1
        if (narrow[i]) count_next[23:16] = 8'h00; // RULE19
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) measure_count[i] <= COUNT_RESET;
        else if (wr_count) measure_count[i] <= put_byte(measure_count[i], idx - REG_COUNT, wdata); // RULE2
        else if (clear_req) measure_count[i] <= COUNT_RESET; // RULE7
        else if (step) measure_count[i] <= count_next;
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) period_limit[i] <= LIMIT_RESET;
        else if (wr_limit) period_limit[i] <= put_byte(period_limit[i], idx - REG_LIMIT, wdata); // RULE15
      end

      //////////////////////////////////////////////////////////////////////
      // capture latches

      always_ff @(posedge mclk) begin
        if (!rst_n) pulse_width_latch[i] <= COUNT_RESET;
        else if (wr_width) pulse_width_latch[i] <= put_byte(pulse_width_latch[i], idx - REG_WIDTH, wdata); // RULE15
        else if (wload_req) pulse_width_latch[i] <= measure_count[i]; // RULE10
        else if (step && w_evt) pulse_width_latch[i] <= measure_count[i]; // RULE9
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) period_latch[i] <= COUNT_RESET;
        else if (wr_period) period_latch[i] <= put_byte(period_latch[i], idx - REG_PERIOD, wdata); // RULE15
        else if (pload_req) period_latch[i] <= measure_count[i]; // RULE12
        else if (step && p_evt) period_latch[i] <= measure_count[i]; // RULE11
      end

      //////////////////////////////////////////////////////////////////////
      // configuration and run control

      always_ff @(posedge mclk) begin
        if (!rst_n) clock_source_select[i] <= 3'h0;
        else if (wr_en && sel && idx == REG_CLOCK) clock_source_select[i] <= wdata[2:0]; // RULE3
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          prescale_select[i] <= 2'h0;
          narrow[i] <= 1'b0;
          repeat_on[i] <= 1'b0;
        end else if (wr_en && sel && idx == REG_CTL0) begin
          prescale_select[i] <= wdata[CTL0_PS_LSB +: 2]; // RULE4
          narrow[i] <= wdata[CTL0_NARROW_BIT];
          repeat_on[i] <= wdata[CTL0_REPEAT_BIT];
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          run_request[i] <= 1'b0;
          mode[i] <= MODE_TIMER;
        end else if (wr_en && sel && idx == REG_CTL1) begin
          run_request[i] <= wdata[CTL1_RUN_BIT];
          mode[i] <= measure_mode_t'(wdata[CTL1_MODE_LSB +: 4]);
        end else if (step && acq && !repeat_on[i]) begin
          run_request[i] <= 1'b0; // RULE18
        end
      end

      // run status follows the request through the tick domain
      always_ff @(posedge mclk) begin
        if (!rst_n) running[i] <= 1'b0;
        else if (tick) running[i] <= run_request[i];
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) armed[i] <= 1'b0;
        else if (!run_request[i]) armed[i] <= 1'b0;
        else if (step && arm_clr) armed[i] <= 1'b0;
        else if (step && arm_set) armed[i] <= 1'b1;
      end

      //////////////////////////////////////////////////////////////////////
      // interrupts: sticky, cleared by reading, a new event wins

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          irq_status[i] <= 2'h0;
        end else begin
          irq_status[i] <= ((rd_en && sel && idx == REG_IRQ_STAT) ? 2'h0 : irq_status[i])
                           | {step && acq, step && match && !hw_reset}; // RULE5 RULE13
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) irq_mask[i] <= 2'h0;
        else if (wr_en && sel && idx == REG_IRQ_MASK) irq_mask[i] <= wdata[1:0];
      end

      assign irq_unit[i] = |(irq_status[i] & irq_mask[i]);

      //////////////////////////////////////////////////////////////////////
      // read view

      always_comb begin
        rd_view[i] = 8'h00;
        if (in_group(idx, REG_COUNT)) rd_view[i] = get_byte(measure_count[i], idx - REG_COUNT);
        else if (in_group(idx, REG_LIMIT)) rd_view[i] = get_byte(period_limit[i], idx - REG_LIMIT);
        else if (in_group(idx, REG_WIDTH)) rd_view[i] = get_byte(pulse_width_latch[i], idx - REG_WIDTH);
        else if (in_group(idx, REG_PERIOD)) rd_view[i] = get_byte(period_latch[i], idx - REG_PERIOD);
        else if (idx == REG_CLOCK) rd_view[i] = {5'h00, clock_source_select[i]};
        else if (idx == REG_CTL0) rd_view[i] = {4'h0, repeat_on[i], narrow[i], prescale_select[i]};
        else if (idx == REG_CTL1) rd_view[i] = {run_request[i], 3'h0, mode[i]};
        else if (idx == REG_STATUS) begin
          rd_view[i][STAT_RUN_BIT] = running[i];
          rd_view[i][STAT_WIN_BIT] = win_ev.level; // RULE14
          rd_view[i][STAT_SIG_BIT] = sig_ev.level; // RULE14
        end
        else if (idx == REG_IRQ_STAT) rd_view[i] = {6'h00, irq_status[i]};
        else if (idx == REG_IRQ_MASK) rd_view[i] = {6'h00, irq_mask[i]};
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // shared outputs

  always_ff @(posedge mclk) begin
    if (!rst_n) rdata <= 8'h00;
    else if (rd_en) rdata <= rd_view[addr[5]];
    else rdata <= 8'h00;
  end

  assign irq = |irq_unit;
endmodule
`default_nettype wire

//--- verification/measure_timer_properties.sv
// port-level assertions for the measurement timer core
// assumes the byte register port and the single mclk domain
`timescale 1ns/1ns
`default_nettype none
module measure_timer_properties
  import measure_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic irq
);
  logic [1:0] mask0;
  logic [1:0] mask1;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // shadow of both interrupt masks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask0 <= 2'h0;
      mask1 <= 2'h0;
    end else if (wr_en && addr[4:0] == REG_IRQ_MASK && !addr[5]) begin
      mask0 <= wdata[1:0];
    end else if (wr_en && addr[4:0] == REG_IRQ_MASK) begin
      mask1 <= wdata[1:0];
    end
  end

  ////////////////////////////////////////
  a_read_idle_zero: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("rdata not zero outside read cycle");
  a_reset_quiet: assert property (!$past(rst_n) |-> rdata == 8'h00 && !irq)
    else $error("outputs not quiet after reset");
  a_unmapped_reads_zero: assert property (rd_en && addr[4:0] > 5'h11 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_action_bits_zero: assert property (rd_en && addr[4:0] == REG_STATUS |=> rdata[7:6] == 2'h0 && !rdata[4])
    else $error("status action bits read set");
  a_irq_needs_mask: assert property (irq |-> (mask0 | mask1) != 2'h0)
    else $error("irq high with all masks clear");
  a_limit_readback: assert property (
    wr_en && addr[4:0] inside {5'h03, 5'h04, 5'h05} ##1 rd_en && addr == $past(addr)
    |=> rdata == $past(wdata, 2))
    else $error("period limit byte not read back");
  a_mask_readback: assert property (
    wr_en && addr[4:0] == REG_IRQ_MASK ##1 rd_en && addr == $past(addr)
    |=> (rdata & 8'h03) == ($past(wdata, 2) & 8'h03))
    else $error("mask not read back");
  a_clock_sel_readback: assert property (
    wr_en && addr[4:0] == REG_CLOCK ##1 rd_en && addr == $past(addr)
    |=> (rdata & 8'h07) == ($past(wdata, 2) & 8'h07))
    else $error("clock select not read back");
endmodule

bind signal_measure_timer_core measure_timer_properties i_props (
  .mclk(mclk),
  .rst_n(rst_n),
  .addr(addr),
  .wdata(wdata),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rdata(rdata),
  .irq(irq)
);
`default_nettype wire

//--- verification/measure_sources.sv
// on-chip oscillator ticks and window and signal sources
// assumes levels requested by the bench, all on mclk
`timescale 1ns/1ns
`default_nettype none
module measure_sources (
  input wire logic mclk,
  input wire logic [1:0] win_req,
  input wire logic [1:0] sig_req,
  output logic fast_tick = 1'b0,
  output logic slow_tick = 1'b0,
  output logic mid_tick = 1'b0,
  output logic [1:0] window_in = 2'h0,
  output logic [1:0] signal_in = 2'h0
);
  logic [2:0] phase = 3'h0;
  always @(posedge mclk) begin
    phase <= phase + 3'h1;
    fast_tick <= phase[0];
    slow_tick <= (phase == 3'h7);
    mid_tick <= 1'b1;
    window_in <= win_req;
    signal_in <= sig_req;
  end
endmodule
`default_nettype wire

//--- verification/tb_signal_measure_timer_core.sv
// self-checking bench for the measurement timer core
// assumes the partner source model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_signal_measure_timer_core;
  import measure_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic fast_tick, slow_tick, mid_tick;
  logic [1:0] window_in, signal_in;
  logic [1:0] win_req = 2'h0;
  logic [1:0] sig_req = 2'h0;
  logic [23:0] v;
  logic [7:0] b;
  int bad_count = 0;
  int n_compared = 0;
  always #50 mclk = ~mclk;

  measure_sources i_src (.mclk(mclk), .win_req(win_req), .sig_req(sig_req), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .mid_tick(mid_tick), .window_in(window_in), .signal_in(signal_in));
  signal_measure_timer_core i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fast_internal_oscillator_tick(fast_tick),
    .slow_internal_oscillator_tick(slow_tick), .mid_internal_oscillator_tick(mid_tick),
    .window_in(window_in), .signal_in(signal_in), .irq(irq));

  ////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask
  task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {16'h0, e}, {16'h0, d});
  endtask
  task automatic cyc(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic w24(input logic [5:0] a, input logic [23:0] d);
    wr(a, d[7:0]);
    wr(a + 6'h1, d[15:8]);
    wr(a + 6'h2, d[23:16]);
  endtask
  task automatic r24(input logic [5:0] a, output logic [23:0] d);
    rd(a, d[7:0]);
    rd(a + 6'h1, d[15:8]);
    rd(a + 6'h2, d[23:16]);
  endtask
  task automatic wirq();
    int i;
    cyc(0);
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk);
    if (irq !== 1'b1) begin
      bad_count++;
      $display("[ERR] irq expected 1 seen %b", irq);
      wrap_up();
    end
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    $display("[ERR] run expected done seen timeout");
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    r24(6'h03, v); chk("limit", LIMIT_RESET, v);
    r24(6'h00, v); chk("count", COUNT_RESET, v);
    wr(6'h12, 8'h5a); rc("unmapped", 6'h12, 8'h00);
    w24(6'h00, 24'h56_3412); r24(6'h00, v); chk("count", 24'h56_3412, v);
    w24(6'h06, 24'ha1_b2c3); r24(6'h06, v); chk("width", 24'ha1_b2c3, v);
    w24(6'h09, 24'h0f_1e2d); r24(6'h09, v); chk("period", 24'h0f_1e2d, v);
    w24(6'h03, 24'h00_0002); rc("limit", 6'h05, 8'h00);
    wr(6'h0c, 8'h05); rc("clock", 6'h0c, 8'h05);
    wr(6'h0f, 8'h80); r24(6'h06, v); chk("width", 24'h56_3412, v);
    wr(6'h0f, 8'h40); r24(6'h09, v); chk("period", 24'h56_3412, v);
    rd(6'h0f, b); chk("status", 24'h0, {16'h0, b & 8'h07});
    wr(6'h0f, 8'h10); r24(6'h00, v); chk("count", COUNT_RESET, v);
    // rollover at limit 2, masked in then out
    wr(6'h0c, 8'h00); wr(6'h11, 8'h01); rc("mask", 6'h11, 8'h01);
    wr(6'h0e, 8'h80);
    wirq();
    wr(6'h0e, 8'h00); r24(6'h00, v); chk("count_le_limit", 24'h1, {23'h0, v <= 24'h2});
    rc("irq_stat", 6'h10, 8'h01); rc("irq_stat", 6'h10, 8'h00);
    chk("irq", 24'h0, {23'h0, irq});
    wr(6'h11, 8'h00); wr(6'h0e, 8'h80); cyc(10);
    wr(6'h0e, 8'h00); rc("irq_stat", 6'h10, 8'h01);
    // every clock source, then prescale 1:8
    w24(6'h03, LIMIT_RESET);
    for (int s = 0; s < 6; s++) begin
      wr(6'h0f, 8'h10); wr(6'h0c, 8'(s)); wr(6'h0e, 8'h80); cyc(64);
      wr(6'h0e, 8'h00); r24(6'h00, v); chk("count_moved", {23'h0, s < 5}, {23'h0, v != 24'h0});
    end
    wr(6'h0f, 8'h10); wr(6'h0c, 8'h00); wr(6'h0d, 8'h03); wr(6'h0e, 8'h80);
    win_req <= 2'h1; sig_req <= 2'h1; cyc(79);
    rd(6'h0f, b); chk("status", 24'h7, {16'h0, b & 8'h07});
    wr(6'h0e, 8'h00); r24(6'h00, v); chk("prescaled", 24'h1, {23'h0, v >= 24'd9 && v <= 24'd11});
    win_req <= 2'h2; sig_req <= 2'h0;
    // carry into the upper byte, then 16-bit rollover
    wr(6'h0d, 8'h00); w24(6'h00, 24'h00_fffe); wr(6'h0e, 8'h80); cyc(8);
    wr(6'h0e, 8'h00); r24(6'h00, v); chk("upper", 24'h1, {16'h0, v[23:16]});
    rd(6'h2f, b); chk("levels1", 24'h2, {16'h0, b & 8'h03});
    r24(6'h20, v); chk("count1", COUNT_RESET, v);
    rc("limit1", 6'h25, 8'hff);
    wr(6'h0d, 8'h04); w24(6'h00, 24'h05_fffd); w24(6'h03, 24'h12_ffff);
    rd(6'h10, b); wr(6'h11, 8'h01); wr(6'h0e, 8'h80);
    wirq();
    wr(6'h0e, 8'h00); r24(6'h00, v);
    chk("upper16", 24'h0, {16'h0, v[23:16]});
    chk("low16", 24'h1, {23'h0, v[15:0] < 16'h4});
    // period and duty, repeated then single
    w24(6'h03, LIMIT_RESET); wr(6'h0d, 8'h08); rd(6'h10, b); wr(6'h11, 8'h02);
    wr(6'h0f, 8'h10); wr(6'h0e, 8'h82);
    sig_req <= 2'h1; cyc(20); sig_req <= 2'h0; cyc(30); sig_req <= 2'h1; cyc(10);
    chk("irq", 24'h1, {23'h0, irq});
    rd(6'h0f, b); chk("running", 24'h1, {23'h0, b[2]});
    wr(6'h0e, 8'h02);
    r24(6'h06, v); chk("width_near_20", 24'h1, {23'h0, v >= 24'd18 && v <= 24'd22});
    r24(6'h09, v); chk("period_near_50", 24'h1, {23'h0, v >= 24'd48 && v <= 24'd52});
    rc("irq_stat", 6'h10, 8'h02);
    sig_req <= 2'h0; wr(6'h0d, 8'h00); wr(6'h0e, 8'h82); cyc(10);
    sig_req <= 2'h1; cyc(5); sig_req <= 2'h0; cyc(5); sig_req <= 2'h1; cyc(10);
    rd(6'h0f, b); chk("running", 24'h0, {23'h0, b[2]});
    rd(6'h0e, b); chk("run_request", 24'h0, {23'h0, b[7]});
    // capture on window edges, then gated timer
    wr(6'h0f, 8'h10); wr(6'h0d, 8'h08); wr(6'h0e, 8'h87); cyc(10);
    win_req <= 2'h3; cyc(20); win_req <= 2'h2; cyc(10); wr(6'h0e, 8'h07);
    r24(6'h09, v); chk("cap_rise", 24'h1, {23'h0, v >= 24'd12 && v <= 24'd14});
    r24(6'h06, v); chk("cap_fall", 24'h1, {23'h0, v >= 24'd32 && v <= 24'd34});
    wr(6'h0f, 8'h10); wr(6'h0e, 8'h81); cyc(10); sig_req <= 2'h0; cyc(10); wr(6'h0e, 8'h01);
    r24(6'h06, v); chk("gated_width", 24'h1, {23'h0, v >= 24'd12 && v <= 24'd14});
    r24(6'h00, v); chk("gated_count", 24'h1, {23'h0, v >= 24'd12 && v <= 24'd14});
    cyc(2);
    wrap_up();
  end
endmodule
`default_nettype wire
